// file: rtl/sleep_reset_defines.vh
// Constants for the sleep, reset and watchdog controller.
// Assumes inclusion by bare name from rtl files only.
`ifndef SLEEP_RESET_DEFINES_VH
`define SLEEP_RESET_DEFINES_VH

// ----------------------------------------
// Register word indices (byte addr = 4*idx)
// ----------------------------------------
`define IDX_SLEEP_CMD      6'h15
`define IDX_WDOG_CLEAR     6'h16
`define IDX_OPMODE         6'h17
`define IDX_SUPPLY_MON     6'h1c
`define IDX_STATUS         6'h1d

// ----------------------------------------
// Magic values and field positions
// ----------------------------------------
`define SLEEP_MAGIC        8'h5a
`define WDOG_MAGIC         8'ha5
`define OPM_CLKSEL_BIT     7
`define OPM_RTC_EN_BIT     3
`define SMON_EN_BIT        4
`define SMON_STAT_BIT      7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OPM_CLKSEL_RST     1'b1
`define OPM_RTC_EN_RST     1'b1
`define SMON_EN_RST        1'b0

// ----------------------------------------
// Timing (clock 200 MHz)
// ----------------------------------------
`define CLK_MHZ            200
`define RESET_HOLD_MS      125
`define RESET_HOLD_CYC     (`RESET_HOLD_MS * `CLK_MHZ * 1000)
`define STAB_FAST_CYC      512
`define STAB_ISLOW_CYC     4
`define STAB_XSLOW_CYC     1024
`define WDOG_MIN_MS        1500
`define SLOW_HZ            32768
`define WDOG_SLOW_CYC      ((`WDOG_MIN_MS * `SLOW_HZ + 999) / 1000)

`endif

// file: rtl/edge_counter.v
// Counts enable pulses; done when the count reaches a limit.
// Assumes enable pulses come from the same clock domain.
`timescale 1ns/1ps
module edge_counter (
	// Clock and reset
	input  wire        i_sys_clk,
	input  wire        i_reset,
	// Control
	input  wire        i_clear,
	input  wire        i_tick,
	input  wire [31:0] i_limit,
	// Status
	output wire        o_done
);
	reg [31:0] count_q;

	// Saturating count, clear takes priority
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			count_q <= 32'h0;
		end else if (i_clear) begin
			count_q <= 32'h0;
		end else if (i_tick && !o_done) begin
			count_q <= count_q + 32'h1;
		end
	end

	assign o_done = (count_q >= i_limit);
endmodule // edge_counter

// file: rtl/sleep_reset_watchdog_ctrl.v
// Low-power mode and reset sequencer with watchdog and supply monitor.
// Assumes a Wishbone classic master, slow-clock and wake sources from pins.
//
// Functional notes
// [RL1] Sleep magic write with counter enabled enters standby.
// [RL2] Standby stops fast oscillator and CPU, slow clock keeps running.
// [RL3] Standby wakes on key change, timers, ticks or external interrupt.
// [RL4] Wake waits 512 fast, 4 internal slow or 1024 crystal cycles.
// [RL5] After stabilisation execution resumes after the sleep write.
// [RL6] Wake resumes normal if clock-select is 1, else slow mode.
// [RL7] Sleep magic write with counter disabled enters halt.
// [RL8] Halt stops both oscillators, CPU and all peripherals.
// [RL9] Halt wakes only on key change or external interrupt.
// [RL10] Reset pin during low power runs full reset, not wake.
// [RL11] Sleep command register is 8-bit write-only, magic requests sleep.
// [RL12] Each reset procedure lasts at least 125 ms.
// [RL13] Reset sources: power-on, low supply, reset pin, watchdog.
// [RL14] Power-on runs reset automatically then starts at reset vector.
// [RL15] Low supply report generates a low-voltage reset.
// [RL16] Reset pin enabled by option; rising edge triggers reset.
// [RL17] Enabled watchdog counts slow clock, resets after about 1.5 s.
// [RL18] Writing A5 to watchdog clear register clears the count.
// [RL19] Supply monitor enable is bit 4, read-write, reset disabled.
// [RL20] Monitor bit 7 reads high when supply below level, if enabled.
// [RL21] Software copies pad levels to port registers before sleeping.
// [RL22] Software clears port data bits before entering halt.
// [RL23] Clock-select 1 selects fast clock, 0 selects slow clock.
// [RL24] Bit 3 enables real-time counter, resets enabled, picks standby.
// [RL25] Sleep writes other than magic are ignored.
// [RL26] Watchdog writes other than magic do not clear the count.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "sleep_reset_defines.vh"
module sleep_reset_watchdog_ctrl #(
	parameter [31:0] RESET_HOLD_CYC = `RESET_HOLD_CYC
) (
	// Clock and reset
	input  wire        i_sys_clk,
	input  wire        i_reset,
	// Wishbone classic slave
	input  wire        i_wb_cyc,
	input  wire        i_wb_stb,
	input  wire        i_wb_we,
	input  wire [7:0]  i_wb_adr,
	input  wire [3:0]  i_wb_sel,
	input  wire [31:0] i_wb_dat,
	output reg  [31:0] o_wb_dat,
	output reg         o_wb_ack,
	// Pins and asynchronous sources
	input  wire        i_slow_osc_clock,
	input  wire        i_key_change,
	input  wire        i_timer_irq,
	input  wire        i_fast_tick_interrupt,
	input  wire        i_slow_tick_interrupt,
	input  wire        i_ext_irq,
	input  wire        i_reset_pin,
	input  wire        i_supply_low,
	input  wire        i_brownout,
	// Options
	input  wire        i_opt_reset_pin_en,
	input  wire        i_opt_watchdog_en,
	input  wire        i_opt_crystal_slow_osc,
	// Outputs to the core
	output reg         o_cpu_reset,
	output reg         o_cpu_run,
	output reg         o_fast_osc_en,
	output reg         o_slow_osc_en,
	output reg         o_periph_en,
	output reg         o_cpu_clk_fast,
	output reg         o_rtc_en,
	output reg  [1:0]  o_reset_cause
);
	// ----------------------------------------
	// States and local codes
	// ----------------------------------------
	localparam [2:0] ST_RESET   = 3'd0;
	localparam [2:0] ST_RUN     = 3'd1;
	localparam [2:0] ST_STANDBY = 3'd2;
	localparam [2:0] ST_HALT    = 3'd3;
	localparam [2:0] ST_STAB    = 3'd4;
	localparam [1:0] CAUSE_POR  = 2'd0;
	localparam [1:0] CAUSE_LVR  = 2'd1;
	localparam [1:0] CAUSE_PIN  = 2'd2;
	localparam [1:0] CAUSE_WDOG = 2'd3;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [8:0] sync1_q;
	reg [8:0] sync2_q;
	reg       slow_prev_q;
	reg       pin_prev_q;
	wire [8:0] async_in = {i_brownout, i_supply_low, i_reset_pin, i_ext_irq,
		i_slow_tick_interrupt, i_fast_tick_interrupt, i_timer_irq, i_key_change,
		i_slow_osc_clock};
	wire s_slow    = sync2_q[0];
	wire s_key     = sync2_q[1];
	wire s_timer   = sync2_q[2];
	wire s_ftick   = sync2_q[3];
	wire s_stick   = sync2_q[4];
	wire s_ext     = sync2_q[5];
	wire s_pin     = sync2_q[6];
	wire s_sup_low = sync2_q[7];
	wire s_brown   = sync2_q[8];

	// Two stages before any logic looks at a pin
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1_q     <= 9'h0;
			sync2_q     <= 9'h0;
			slow_prev_q <= 1'b0;
			pin_prev_q  <= 1'b0;
		end else begin
			sync1_q     <= async_in;
			sync2_q     <= sync1_q;
			slow_prev_q <= s_slow;
			pin_prev_q  <= s_pin;
		end
	end

	// Slow clock rising edge as a one-cycle enable
	wire slow_tick = s_slow & ~slow_prev_q;
	wire pin_rise  = i_opt_reset_pin_en & s_pin & ~pin_prev_q; // see [RL16]

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	reg        clksel_q;
	reg        rtc_en_q;
	reg        smon_en_q;
	wire [5:0] idx    = i_wb_adr[7:2];
	wire       wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire       wr_lo  = wb_req & i_wb_we & i_wb_sel[0];

	// Magic match on the low byte of an addressed write
	function magic_hit;
		input [5:0] f_idx;
		input [5:0] f_want;
		input [7:0] f_data;
		input [7:0] f_magic;
		begin
			magic_hit = (f_idx == f_want) && (f_data == f_magic);
		end
	endfunction

	wire sleep_wr = wr_lo & magic_hit(idx, `IDX_SLEEP_CMD, i_wb_dat[7:0], `SLEEP_MAGIC); // see [RL11] see [RL25]
	wire wdog_wr  = wr_lo & magic_hit(idx, `IDX_WDOG_CLEAR, i_wb_dat[7:0], `WDOG_MAGIC); // see [RL18] see [RL26]

	reg [2:0] state_q;
	reg [2:0] state_d;

	// One-cycle ack; unmapped reads return zero, writes dropped
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_wb_ack  <= 1'b0;
			o_wb_dat  <= 32'h0;
			clksel_q  <= `OPM_CLKSEL_RST;
			rtc_en_q  <= `OPM_RTC_EN_RST;
			smon_en_q <= `SMON_EN_RST;
		end else begin
			o_wb_ack <= wb_req;
			if (state_q == ST_RESET) begin
				clksel_q  <= `OPM_CLKSEL_RST;
				rtc_en_q  <= `OPM_RTC_EN_RST;
				smon_en_q <= `SMON_EN_RST;
			end else if (wr_lo && idx == `IDX_OPMODE) begin
				clksel_q <= i_wb_dat[`OPM_CLKSEL_BIT]; // see [RL23]
				rtc_en_q <= i_wb_dat[`OPM_RTC_EN_BIT]; // see [RL24]
			end else if (wr_lo && idx == `IDX_SUPPLY_MON) begin
				smon_en_q <= i_wb_dat[`SMON_EN_BIT]; // see [RL19]
			end
			o_wb_dat <= 32'h0;
			if (wb_req && !i_wb_we) begin
				case (idx)
					`IDX_OPMODE: begin
						o_wb_dat[`OPM_CLKSEL_BIT] <= clksel_q;
						o_wb_dat[`OPM_RTC_EN_BIT] <= rtc_en_q;
					end
					`IDX_SUPPLY_MON: begin
						o_wb_dat[`SMON_EN_BIT]   <= smon_en_q;
						o_wb_dat[`SMON_STAT_BIT] <= smon_en_q & s_sup_low; // see [RL20]
					end
					`IDX_STATUS: begin
						o_wb_dat[2:0] <= state_q;
						o_wb_dat[5:4] <= o_reset_cause;
					end
					default: begin
						o_wb_dat <= 32'h0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Reset sources and watchdog
	// ----------------------------------------
	wire wdog_done;
	wire hold_done;
	wire stab_done;
	wire wdog_fire = i_opt_watchdog_en & wdog_done & (state_q == ST_RUN); // see [RL17]
	wire reset_req = s_brown | pin_rise | wdog_fire; // see [RL13] see [RL15] see [RL10]

	// Watchdog runs off the slow clock while the program executes
	edge_counter u_wdog (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_clear   (wdog_wr | (state_q != ST_RUN) | ~i_opt_watchdog_en), // see [RL18]
		.i_tick    (slow_tick),
		.i_limit   (`WDOG_SLOW_CYC),
		.o_done    (wdog_done)
	);

	// Reset hold counts system cycles, restarted by every new source
	reg [31:0] hold_cnt_q;
	assign hold_done = (hold_cnt_q >= RESET_HOLD_CYC);
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			hold_cnt_q <= 32'h0;
		end else if (state_q != ST_RESET || reset_req) begin
			hold_cnt_q <= 32'h0;
		end else if (!hold_done) begin
			hold_cnt_q <= hold_cnt_q + 32'h1; // see [RL12]
		end
	end

	// Stabilisation limit: fast clock counts system cycles, slow counts slow edges
	reg  [31:0] stab_cnt_q;
	wire [31:0] slow_lim = i_opt_crystal_slow_osc ? `STAB_XSLOW_CYC : `STAB_ISLOW_CYC;
	wire        stab_fast = clksel_q;
	assign stab_done = stab_fast ? (stab_cnt_q >= `STAB_FAST_CYC) : (stab_cnt_q >= slow_lim);
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			stab_cnt_q <= 32'h0;
		end else if (state_q != ST_STAB) begin
			stab_cnt_q <= 32'h0;
		end else if (!stab_done && (stab_fast || slow_tick)) begin
			stab_cnt_q <= stab_cnt_q + 32'h1; // see [RL4]
		end
	end

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	wire wake_standby = s_key | s_timer | s_ftick | s_stick | s_ext; // see [RL3]
	wire wake_halt    = s_key | s_ext; // see [RL9]

	// Reset request beats any wake; stays in reset while brownout persists
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RESET: begin
				if (hold_done && !s_brown) begin
					state_d = ST_RUN; // see [RL14]
				end
			end
			ST_RUN: begin
				if (sleep_wr) begin
					state_d = rtc_en_q ? ST_STANDBY : ST_HALT; // see [RL1] see [RL7]
				end
			end
			ST_STANDBY: begin
				if (wake_standby) begin
					state_d = ST_STAB;
				end
			end
			ST_HALT: begin
				if (wake_halt) begin
					state_d = ST_STAB;
				end
			end
			ST_STAB: begin
				if (stab_done) begin
					state_d = ST_RUN; // see [RL5]
				end
			end
			default: begin
				state_d = ST_RESET;
			end
		endcase
		if (reset_req) begin
			state_d = ST_RESET; // see [RL10]
		end
	end

	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state_q       <= ST_RESET;
			o_reset_cause <= CAUSE_POR;
		end else begin
			state_q <= state_d;
			if (s_brown) begin
				o_reset_cause <= CAUSE_LVR;
			end else if (pin_rise) begin
				o_reset_cause <= CAUSE_PIN;
			end else if (wdog_fire) begin
				o_reset_cause <= CAUSE_WDOG;
			end
		end
	end

	// ----------------------------------------
	// Clock and run controls
	// ----------------------------------------
	// Registered so the core sees glitch-free enables
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_cpu_reset    <= 1'b1;
			o_cpu_run      <= 1'b0;
			o_fast_osc_en  <= 1'b1;
			o_slow_osc_en  <= 1'b1;
			o_periph_en    <= 1'b0;
			o_cpu_clk_fast <= 1'b1;
			o_rtc_en       <= 1'b1;
		end else begin
			o_cpu_reset    <= (state_d == ST_RESET);
			o_cpu_run      <= (state_d == ST_RUN);
			o_fast_osc_en  <= (state_d == ST_RESET) | ((state_d == ST_RUN || state_d == ST_STAB) & clksel_q); // see [RL2] see [RL6]
			o_slow_osc_en  <= (state_d != ST_HALT); // see [RL8]
			o_periph_en    <= (state_d == ST_RUN) | (state_d == ST_STANDBY); // see [RL8]
			o_cpu_clk_fast <= clksel_q; // see [RL6] see [RL23]
			o_rtc_en       <= rtc_en_q & (state_d != ST_HALT); // see [RL24] see [RL2]
		end
	end
endmodule // sleep_reset_watchdog_ctrl

// file: bench/sleep_reset_watchdog_ctrl_asserts.sv
// Checker for the sleep, reset and watchdog controller.
// Assumes it is bound to the controller top; one clock domain.
`timescale 1ns/1ps
module sleep_reset_watchdog_ctrl_asserts (
	// Clock, reset and bus
	input logic        i_sys_clk,
	input logic        i_reset,
	input logic        i_wb_cyc,
	input logic        i_wb_stb,
	input logic        i_wb_we,
	input logic [7:0]  i_wb_adr,
	input logic [3:0]  i_wb_sel,
	input logic [31:0] i_wb_dat,
	input logic [31:0] o_wb_dat,
	input logic        o_wb_ack,
	// Sources and mode outputs
	input logic        i_key_change,
	input logic        i_ext_irq,
	input logic        i_reset_pin,
	input logic        i_brownout,
	input logic        i_opt_reset_pin_en,
	input logic        o_cpu_reset,
	input logic        o_cpu_run,
	input logic        o_fast_osc_en,
	input logic        o_slow_osc_en,
	input logic        o_periph_en,
	input logic        o_cpu_clk_fast,
	input logic        o_rtc_en
);
	// ----
	// Sleep register write seen at the edge that takes it
	// ----
	wire slp_wr = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr[7:2] == 6'h15;
	wire magic  = i_wb_dat[7:0] == 8'h5a;
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not answered on the next edge");
	dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data outside the ack cycle");
	standby_entry_a: assert property (slp_wr && magic && o_cpu_run && o_rtc_en |-> ##2
		(!o_cpu_run && !o_fast_osc_en && o_slow_osc_en && o_periph_en)) else $error("standby not entered");
	halt_entry_a: assert property (slp_wr && magic && o_cpu_run && !o_rtc_en |-> ##2
		(!o_cpu_run && !o_fast_osc_en && !o_slow_osc_en && !o_periph_en)) else $error("halt not entered");
	sleep_ignored_a: assert property (slp_wr && !magic && o_cpu_run |-> ##2 o_cpu_run)
		else $error("non-magic sleep write changed mode");
	halt_wake_a: assert property ((!i_key_change && !i_ext_irq && !i_reset_pin && !i_brownout)[*4]
		##0 !o_slow_osc_en |=> !o_slow_osc_en) else $error("halt left without key or external wake");
	pin_reset_a: assert property ($rose(i_reset_pin) && i_opt_reset_pin_en |-> ##[1:8] o_cpu_reset)
		else $error("reset pin rise gave no reset");
	brownout_hold_a: assert property (i_brownout [*8] |-> o_cpu_reset)
		else $error("low supply did not hold reset");
	clk_select_a: assert property (o_cpu_run |-> o_fast_osc_en == o_cpu_clk_fast)
		else $error("fast oscillator disagrees with clock select");
	reset_state_a: assert property (o_cpu_reset |-> !o_cpu_run && o_fast_osc_en)
		else $error("running during reset");
endmodule // sleep_reset_watchdog_ctrl_asserts

bind sleep_reset_watchdog_ctrl sleep_reset_watchdog_ctrl_asserts i_chk (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_key_change(i_key_change), .i_ext_irq(i_ext_irq),
	.i_reset_pin(i_reset_pin), .i_brownout(i_brownout), .i_opt_reset_pin_en(i_opt_reset_pin_en),
	.o_cpu_reset(o_cpu_reset), .o_cpu_run(o_cpu_run), .o_fast_osc_en(o_fast_osc_en),
	.o_slow_osc_en(o_slow_osc_en), .o_periph_en(o_periph_en), .o_cpu_clk_fast(o_cpu_clk_fast),
	.o_rtc_en(o_rtc_en));

// file: bench/sleep_reset_watchdog_ctrl_tb_top.sv
// Self-checking bench for the sleep, reset and watchdog controller.
// Assumes a short reset hold parameter and a fast slow-clock stand-in.
`timescale 1ns/1ps
module sleep_reset_watchdog_ctrl_tb_top;
	localparam int HOLD = 50;
	// ----
	// Bench signals
	// ----
	logic        clk = 1'h0, rst = 1'h1, req = 1'h0, we = 1'h0, slow = 1'h0, pin = 1'h0, bo = 1'h0;
	logic        sup = 1'h0;
	logic [7:0]  adr = 8'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic [4:0]  wk = 5'h0;
	wire  [31:0] dat_o;
	wire  [1:0]  cause;
	wire         ack, c_rst, run, fast_en, slow_en, per_en, clk_fast, rtc_en;
	int          err_total = 0, compares = 0, ticks = 0, t0;

	// Slow clock far faster than real so stabilisation stays short
	always #2.5 clk = ~clk;
	always #10 slow = ~slow;
	always @(posedge clk) ticks <= ticks + 1;

	sleep_reset_watchdog_ctrl #(.RESET_HOLD_CYC(32'h32)) i_dut (
		.i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(dat_o), .o_wb_ack(ack),
		.i_slow_osc_clock(slow), .i_key_change(wk[0]), .i_timer_irq(wk[1]),
		.i_fast_tick_interrupt(wk[2]), .i_slow_tick_interrupt(wk[3]), .i_ext_irq(wk[4]),
		.i_reset_pin(pin), .i_supply_low(sup), .i_brownout(bo), .i_opt_reset_pin_en(1'h1),
		.i_opt_watchdog_en(1'h1), .i_opt_crystal_slow_osc(1'h0), .o_cpu_reset(c_rst),
		.o_cpu_run(run), .o_fast_osc_en(fast_en), .o_slow_osc_en(slow_en), .o_periph_en(per_en),
		.o_cpu_clk_fast(clk_fast), .o_rtc_en(rtc_en), .o_reset_cause(cause));

	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single classic cycle; waits for ack, bounded
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		rdat = dat_o;
		req <= 1'h0;
		if (n >= 20) chk(ack, 32'h1);
	endtask

	task automatic wait_run(input int lim, output int n);
		n = 0;
		while (run !== 1'h1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_boot();
		int n;
		bus(1'h0, 8'h74, 32'h0);
		chk(rdat[2:0], 32'h0);
		bus(1'h0, 8'h5c, 32'h0);
		chk(rdat & 32'h88, 32'h88);
		bus(1'h0, 8'h70, 32'h0);
		chk(rdat & 32'h90, 32'h0);
		bus(1'h0, 8'h00, 32'h0);
		chk(rdat, 32'h0);
		wait_run(200, n);
		chk(ticks - t0 >= HOLD && ticks - t0 <= HOLD + 6, 32'h1);
		chk(cause, 32'h0);
		bus(1'h1, 8'h70, 32'h10);
		bus(1'h0, 8'h70, 32'h0);
		chk(rdat & 32'h90, 32'h10);
		sup <= 1'h1;
		repeat (4) @(posedge clk);
		bus(1'h0, 8'h70, 32'h0);
		chk(rdat & 32'h90, 32'h90);
		sup <= 1'h0;
		bus(1'h1, 8'h58, 32'ha5);
		bus(1'h1, 8'h58, 32'h11);
	endtask

	task automatic t_stby(input int s);
		int n;
		bus(1'h1, 8'h54, 32'h33);
		repeat (3) @(posedge clk);
		chk(run, 32'h1);
		bus(1'h1, 8'h54, 32'h5a);
		repeat (3) @(posedge clk);
		chk({run, fast_en, slow_en, per_en}, 32'h3);
		wk <= 5'h1 << s;
		wait_run(700, n);
		wk <= 5'h0;
		chk(n >= 512 && n <= 530, 32'h1);
		chk({fast_en, clk_fast}, 32'h3);
	endtask

	task automatic t_halt(input logic [4:0] w);
		int n;
		bus(1'h1, 8'h5c, 32'h0);
		repeat (3) @(posedge clk);
		chk({fast_en, clk_fast, rtc_en}, 32'h0);
		bus(1'h1, 8'h54, 32'h5a);
		wk <= 5'he;
		repeat (20) @(posedge clk);
		chk({run, fast_en, slow_en, per_en}, 32'h0);
		wk <= w;
		wait_run(100, n);
		wk <= 5'h0;
		chk(n >= 12 && n < 40, 32'h1);
		chk(fast_en, 32'h0);
		bus(1'h1, 8'h5c, 32'h88);
	endtask

	// Reset pin during standby, then low supply held past the hold
	task automatic t_resets();
		int n;
		bus(1'h1, 8'h54, 32'h5a);
		repeat (3) @(posedge clk);
		pin <= 1'h1;
		repeat (8) @(posedge clk);
		pin <= 1'h0;
		chk({c_rst, run, cause}, 32'ha);
		wait_run(200, n);
		chk(n >= HOLD - 8, 32'h1);
		bo <= 1'h1;
		repeat (HOLD + 40) @(posedge clk);
		chk({c_rst, run, cause}, 32'h9);
		bo <= 1'h0;
		wait_run(200, n);
		chk(n >= HOLD - 4 && run === 1'h1, 32'h1);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		t0 = ticks;
		t_boot();
		for (int s = 0; s < 5; s++) t_stby(s);
		t_halt(5'h1);
		t_halt(5'h10);
		t_resets();
		final_report();
	end

	// Whole run is near 3000 cycles; this is generous
	initial begin
		#100us;
		err_total++;
		final_report();
	end
endmodule // sleep_reset_watchdog_ctrl_tb_top
